// *** hw/spsr_edge.sv ***
// Purpose: Falling-edge detector for the controller's shift clock
// Assumes: Shift clock input already synchronous to the system clock
// Notes: Edge pulse lasts one system clock cycle
`timescale 1ns/10ps
module spsr_edge (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic level_i,
  output logic fall_o
);
  import spsr_pkg::*;
  logic last_reg;
  logic last_next;

  // Previous level; starts at the idle low, so a low clock at release is no fall
  always_comb begin
    last_next = level_i;
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      last_reg <= SHCLK_IDLE;
    end else begin
      last_reg <= last_next;
    end
  end

  assign fall_o = last_reg & ~level_i; // High-to-low seen this cycle
endmodule : spsr_edge

// *** hw/spsr_pkg.sv ***
// Purpose: Shared constants and types for the 16-stage serial/parallel shift register
// Assumes: Single system clock, all control inputs synchronous to it
// Notes: Mode encoding is internal; the top also drives it out on MODE_O
package spsr_pkg;
  localparam int STAGES = 16;
  localparam logic [15:0] STAGE_RESET = 16'h0000;
  localparam logic [3:0] LAST_STAGE = 4'hf;
  localparam logic SHCLK_IDLE = 1'b0; // Shift clock rests low between frames
  localparam logic [4:0] ROT_IDLE = 5'h00; // No recirculating falls counted yet
  localparam logic [4:0] ROT_FULL = 5'h10; // Falls for one full turn of the register

  typedef enum logic [1:0] {
    SPSR_HOLD = 2'b00,
    SPSR_SER_LOAD = 2'b01,
    SPSR_SER_OUT = 2'b10,
    SPSR_PAR_LOAD = 2'b11
  } spsr_mode_t;
endpackage : spsr_pkg

// *** hw/spsr_top.sv ***
// Purpose: 16-stage shift register with serial/parallel load and recirculating serial out
// Assumes: Controller inputs are synchronous to MCLK_I; shift clock slower than MCLK_I
// Notes: Reset added for simulation sanity; the register itself has no other clear
//   The shift clock is sampled, so each of its phases must last one MCLK_I period or more
//   A fall uses the mode inputs seen at that MCLK_I edge; change them while the clock is low
//   Helper registers near the end exist only for the recirculation checks
`timescale 1ns/10ps
module spsr_top (
  input wire logic MCLK_I,
  input wire logic RST_N_I,
  input wire logic SHIFT_CLOCK_N_I,
  input wire logic UNIT_SELECT_N_I,
  input wire logic DIR_SELECT_I,
  input wire logic FUNCTION_SELECT_I,
  input wire logic [15:0] PARALLEL_IN_I,
  input wire logic SERIAL_PIN_I,
  output logic SERIAL_PIN_O,
  output logic SERIAL_PIN_OE_O,
  output spsr_pkg::spsr_mode_t MODE_O,
  output logic [15:0] STAGES_O
);
  import spsr_pkg::*;

  spsr_mode_t mode;
  logic shclk_fall;
  logic [15:0] stage_reg;
  logic [15:0] stage_next;
  logic shift_in; // Bit that enters stage 0 on a shift
  logic [15:0] stage_shifted; // Contents moved one stage up
  logic [15:0] snap_reg; // Check helper: contents at start of a turn
  logic [15:0] snap_next;
  logic [4:0] rot_count_reg; // Check helper: recirculating falls so far
  logic [4:0] rot_count_next;

  // Falling edges of the shift clock
  spsr_edge u_edge (
    .mclk_i(MCLK_I),
    .rst_n_i(RST_N_I),
    .level_i(SHIFT_CLOCK_N_I),
    .fall_o(shclk_fall)
  );

  // Mode decode from the control inputs
  always_comb begin
    if (UNIT_SELECT_N_I) begin
      mode = SPSR_HOLD;
    end else if (!DIR_SELECT_I) begin
      mode = SPSR_SER_LOAD;
    end else if (!FUNCTION_SELECT_I) begin
      mode = SPSR_SER_OUT;
    end else begin
      mode = SPSR_PAR_LOAD;
    end
  end

  // Bit entering stage 0: pin in serial load, stage 15 when recirculating
  always_comb begin
    if (mode == SPSR_SER_LOAD) begin
      shift_in = SERIAL_PIN_I;
    end else begin
      shift_in = stage_reg[LAST_STAGE];
    end
  end

  // One mux leg per stage; keeps the shift direction in a single place
  for (genvar k = 0; k < STAGES; k++) begin : g_stage
    if (k == 0) begin : g_first
      assign stage_shifted[k] = shift_in;
    end else begin : g_rest
      assign stage_shifted[k] = stage_reg[k - 1];
    end
  end

  // Next stage contents; only a falling shift clock edge changes them
  always_comb begin
    stage_next = stage_reg;
    if (shclk_fall) begin
      case (mode)
        SPSR_HOLD: stage_next = stage_reg;
        SPSR_SER_LOAD: stage_next = stage_shifted;
        SPSR_SER_OUT: stage_next = stage_shifted;
        SPSR_PAR_LOAD: stage_next = PARALLEL_IN_I;
        default: stage_next = stage_reg;
      endcase
    end
  end

  // Stage register, one per stage
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      stage_reg <= STAGE_RESET;
    end else begin
      stage_reg <= stage_next;
    end
  end

  // Pin drive: out only in serial out and parallel load
  assign SERIAL_PIN_OE_O = (mode == SPSR_SER_OUT) || (mode == SPSR_PAR_LOAD);
  assign SERIAL_PIN_O = stage_reg[LAST_STAGE];
  assign MODE_O = mode;
  assign STAGES_O = stage_reg;

  // Check helper: a fall in serial out starts or extends a turn, any other
  // shifting or loading fall ends it, and a fall in hold leaves it alone
  always_comb begin
    snap_next = snap_reg;
    rot_count_next = rot_count_reg;
    if (shclk_fall && mode == SPSR_SER_OUT) begin
      if (rot_count_reg == ROT_IDLE || rot_count_reg == ROT_FULL) begin
        snap_next = stage_reg;
        rot_count_next = 5'h01;
      end else begin
        rot_count_next = rot_count_reg + 5'h01;
      end
    end else if (shclk_fall && mode != SPSR_HOLD) begin
      rot_count_next = ROT_IDLE;
    end
  end

  // Helper registers; nothing but the checks below reads them
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      snap_reg <= STAGE_RESET;
      rot_count_reg <= ROT_IDLE;
    end else begin
      snap_reg <= snap_next;
      rot_count_reg <= rot_count_next;
    end
  end

  // Hold: contents frozen and pin released
  a_hold_keeps: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
    UNIT_SELECT_N_I |=> stage_reg == $past(stage_reg))
    else $error("contents changed in hold");
  a_hold_release: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
    UNIT_SELECT_N_I |-> !SERIAL_PIN_OE_O)
    else $error("pin driven in hold");

  // Serial load: pin bit into stage 0, the rest move up, pin left to the controller
  a_serload_shift: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
    (shclk_fall && mode == SPSR_SER_LOAD) |=>
      stage_reg == {$past(stage_reg[14:0]), $past(SERIAL_PIN_I)})
    else $error("serial load wrong");
  a_serload_top: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
    (shclk_fall && mode == SPSR_SER_LOAD) |=> stage_reg[15] == $past(stage_reg[14]))
    else $error("serial load did not advance");
  a_serload_enter: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
    (shclk_fall && mode == SPSR_SER_LOAD) |=> stage_reg[0] == $past(SERIAL_PIN_I))
    else $error("pin bit missing from stage 0");
  a_serload_float: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
    mode == SPSR_SER_LOAD |-> !SERIAL_PIN_OE_O)
    else $error("pin driven in serial load");
  a_edge_once: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
    shclk_fall |=> !shclk_fall)
    else $error("one clock fall seen twice");

  // Serial out: stage 15 on the pin and back into stage 0
  // The turn check catches a lost or doubled bit that one-step checks can miss
  a_serout_rotate: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
    (shclk_fall && mode == SPSR_SER_OUT) |=>
      stage_reg == {$past(stage_reg[14:0]), $past(stage_reg[15])})
    else $error("recirculation wrong");
  a_serout_drive: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
    mode == SPSR_SER_OUT |-> SERIAL_PIN_OE_O && SERIAL_PIN_O == stage_reg[15])
    else $error("pin not driven in serial out");
  a_serout_wrap: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
    rot_count_reg == ROT_FULL |-> stage_reg == snap_reg)
    else $error("full turn lost data");
  a_turn_bound: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
    rot_count_reg <= ROT_FULL)
    else $error("turn counter overran");

  // Parallel load: all stages at once, pin shows stage 15
  a_parload_take: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
    (shclk_fall && mode == SPSR_PAR_LOAD) |=> stage_reg == $past(PARALLEL_IN_I))
    else $error("parallel load wrong");
  a_parload_drive: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
    mode == SPSR_PAR_LOAD |-> SERIAL_PIN_OE_O && SERIAL_PIN_O == stage_reg[15])
    else $error("pin not driven in parallel load");

  // No fall, no change
  a_no_edge_still: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
    !shclk_fall |=> $stable(stage_reg))
    else $error("change without clock edge");

  // Mode decode, one row of the table each
  a_mode_hold: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
    UNIT_SELECT_N_I |-> mode == SPSR_HOLD)
    else $error("hold not decoded");
  a_mode_serload: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
    (!UNIT_SELECT_N_I && !DIR_SELECT_I) |-> mode == SPSR_SER_LOAD)
    else $error("serial load not decoded");
  a_mode_decode: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
    (!UNIT_SELECT_N_I && DIR_SELECT_I && !FUNCTION_SELECT_I) |-> mode == SPSR_SER_OUT)
    else $error("mode decode wrong");
  a_mode_parload: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
    (!UNIT_SELECT_N_I && DIR_SELECT_I && FUNCTION_SELECT_I) |-> mode == SPSR_PAR_LOAD)
    else $error("parallel load not decoded");

  // Main scenarios
  c_serload: cover property (@(posedge MCLK_I) disable iff (!RST_N_I)
    shclk_fall && mode == SPSR_SER_LOAD);
  c_serout: cover property (@(posedge MCLK_I) disable iff (!RST_N_I)
    shclk_fall && mode == SPSR_SER_OUT);
  c_parload: cover property (@(posedge MCLK_I) disable iff (!RST_N_I)
    shclk_fall && mode == SPSR_PAR_LOAD);
  c_hold_edge: cover property (@(posedge MCLK_I) disable iff (!RST_N_I)
    shclk_fall && mode == SPSR_HOLD);
  c_serout_wrap: cover property (@(posedge MCLK_I) disable iff (!RST_N_I)
    rot_count_reg == ROT_FULL);
endmodule : spsr_top

// *** sim/spsr_ctrl.sv ***
// Purpose: Controller side of the shared serial pin
// Assumes: One party drives at a time
// Notes: Undriven pin toggles, never holds old data
`timescale 1ns/10ps
module spsr_ctrl (
  input wire logic mclk_i,
  input wire logic dev_oe_i,
  input wire logic dev_d_i,
  input wire logic ctl_en_i,
  input wire logic ctl_d_i,
  output logic pin_o
);
  logic last_reg = 1'b0;
  // Resolve the wire; a clash shows unknown
  always_comb begin
    if (dev_oe_i && ctl_en_i) pin_o = 1'bx;
    else if (dev_oe_i) pin_o = dev_d_i;
    else if (ctl_en_i) pin_o = ctl_d_i;
    else pin_o = ~last_reg;
  end
  // Float hazard: stale level must not pass as data
  always_ff @(posedge mclk_i) last_reg <= pin_o;
endmodule : spsr_ctrl

// *** sim/spsr_top_tb.sv ***
// Purpose: Random-mode bench for the shift register
// Assumes: Controls change only while the shift clock is low
// Notes: Reference model is a plain 16-bit vector
`timescale 1ns/10ps
module spsr_top_tb;
  import spsr_pkg::*;
  logic clk = 0, rst_n = 0, sck = 0, us_n = 1, dir = 0, fn = 0, din = 0, pin, sdo, oe;
  logic [15:0] par = 16'h0000, stg, q = 16'h0000, snap = 16'h0000;
  spsr_mode_t mode;
  int fail_count = 0, num_checks = 0;
  spsr_top spsr_top_i (.MCLK_I(clk), .RST_N_I(rst_n), .SHIFT_CLOCK_N_I(sck),
    .UNIT_SELECT_N_I(us_n), .DIR_SELECT_I(dir), .FUNCTION_SELECT_I(fn),
    .PARALLEL_IN_I(par), .SERIAL_PIN_I(pin), .SERIAL_PIN_O(sdo),
    .SERIAL_PIN_OE_O(oe), .MODE_O(mode), .STAGES_O(stg));
  spsr_ctrl spsr_ctrl_i (.mclk_i(clk), .dev_oe_i(oe), .dev_d_i(sdo),
    .ctl_en_i(!us_n && !dir), .ctl_d_i(din), .pin_o(pin));
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] seen);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : report_and_stop
  // One fall under random controls, or selected with {dir, fn} forced when force_mode >= 0
  task automatic op(input int force_mode);
    spsr_mode_t want;
    @(posedge clk);
    #1;
    us_n = force_mode >= 0 ? 1'b0 : ($urandom % 4) == 0;
    dir = force_mode >= 0 ? force_mode[1] : 1'($urandom);
    fn = force_mode >= 0 ? force_mode[0] : 1'($urandom);
    par = 16'($urandom);
    din = 1'($urandom);
    @(posedge clk);
    #1 sck = 1;
    @(posedge clk);
    #1 sck = 0;
    if (!us_n) q = !dir ? {q[14:0], din} : (fn ? par : {q[14:0], q[15]});
    repeat (2) @(posedge clk);
    #1;
    chk("stages", q, stg);
    want = us_n ? SPSR_HOLD : !dir ? SPSR_SER_LOAD : fn ? SPSR_PAR_LOAD : SPSR_SER_OUT;
    chk("mode", 16'(want), 16'(mode));
    chk("oe", 16'(!us_n && dir), 16'(oe));
    if (!us_n && dir) chk("pin", 16'(q[15]), 16'(pin));
  endtask : op
  initial forever #50 clk = ~clk;
  // Main sequence
  initial begin
    void'($urandom(43));
    repeat (5) @(posedge clk);
    #1 rst_n = 1;
    chk("reset", 16'h0000, stg);
    repeat (120) op(-1);
    // Full turn: sixteen recirculating falls bring a parallel word back
    op(3);
    snap = par;
    repeat (16) op(2);
    chk("turn", snap, stg);
    // Mid-run reset in serial load with a 1 on the pin: no false fall at release
    @(posedge clk);
    #1;
    us_n = 0;
    dir = 0;
    din = 1;
    rst_n = 0;
    repeat (2) @(posedge clk);
    #1 rst_n = 1;
    q = 16'h0000;
    repeat (2) @(posedge clk);
    #1;
    chk("rerun", q, stg);
    repeat (20) op(-1);
    report_and_stop();
  end
  // Watchdog, well past the 800 or so cycles of tests
  initial begin
    #400000;
    fail_count++;
    report_and_stop();
  end
endmodule : spsr_top_tb
